// ---- core/sar_conv_ctrl.sv ----
// Conversion control, result register and output bus of an 18-bit SAR converter.
// Assumes host pins and the comparator are asynchronous to mclk; the serial
// port outside takes result_word and serial_enable.
//
// Function
// - A high reset returns the block to its reset state and abandons any conversion.
// - Power-down lets a running conversion finish, then blocks new ones and lowers power.
// - A start input high at the end of acquisition makes the block wait for its falling edge.
// - A start input already low at the end of acquisition starts a conversion at once.
// - The reference buffer is on while its disable input is low and off while it is high.
// - The interface select picks 18-bit, 16-bit word, 8-bit byte or serial with parallel off.
// - In 18-bit format every data pin carries the result bit of the same index.
// - In 16-bit format with word select low pins 2..17 carry bits 2..17 and pin 0 is an input.
// - In 16-bit format with word select high pins 2 and 3 carry bits 0 and 1, the rest zero.
// - In 8-bit format pins 3..9 float and pins 10..17 carry the high or middle byte.
// - In 8-bit format with word select high pins 10..17 carry bits 1:0 low or high, rest zero.
// - The 18-bit result is held in one output register that feeds every output format.
// - Busy rises when a conversion starts and falls when the result is latched.
// - Output pins are driven only while chip select and read are both low.
// - Outside 18-bit format the coding select picks straight binary or two's complement.
`timescale 1ns/1ps
`include "sar_conv_map.svh"
`default_nettype none

module sar_conv_ctrl #(
   parameter int ACQ_CYCLES    = `SAR_ACQ_CYC,
   parameter int SETTLE_CYCLES = `SAR_SETTLE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        power_down_request,
   input  wire logic        conversion_start_n,
   input  wire logic        refbuf_disable,
   input  wire logic        iface_sel0,
   input  wire logic        iface_sel1,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        comp_above,
   input  wire logic [17:0] data_in,
   output logic      [17:0] data_out,
   output logic      [17:0] data_oe,
   output logic             busy,
   output logic             sample_hold,
   output logic      [17:0] dac_trial,
   output logic             refbuf_enable,
   output logic             low_power,
   output logic             serial_enable,
   output logic      [17:0] result_word
);

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers.

   localparam int SW = 11;
   // Reset holds start, buffer disable, chip select and read at their idle high levels.
   localparam logic [SW-1:0] SYNC_RST = 11'h330;

   sar_conv_pkg::host_ctl_s ctl_s;
   logic                    comp_s;
   logic [2:0]              cfg_s;
   logic [SW-1:0]           sync_out;

   sar_sync2 #(
      .W       (SW),
      .RST_VAL (SYNC_RST)
   ) u_sync (
      .mclk     (mclk),
      .rst      (rst),
      .async_in ({power_down_request, conversion_start_n, refbuf_disable,
                  iface_sel1, iface_sel0, cs_n, rd_n, comp_above,
                  data_in[`SAR_PIN_BYTE], data_in[`SAR_PIN_WORD],
                  data_in[`SAR_PIN_CODING]}),
      .sync_out (sync_out)
   );

   assign ctl_s  = sync_out[SW-1:4];
   assign comp_s = sync_out[3];
   assign cfg_s  = sync_out[2:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer.

   sar_conv_pkg::conv_state_e state_q, state_d;
   logic [15:0] acq_cnt_q, acq_cnt_d;
   logic [7:0]  settle_q, settle_d;
   logic [4:0]  bit_q, bit_d;
   logic [17:0] trial_q, trial_d;
   logic [17:0] result_q, result_d;
   logic        busy_q, busy_d;
   logic        cnv_prev_q;

   wire acq_done    = (acq_cnt_q >= 16'(ACQ_CYCLES - 1));
   // A falling edge is taken from the synchronised level, never the raw pin.
   wire cnv_fall    = cnv_prev_q && !ctl_s.conversion_start_n_n;
   wire settle_done = (settle_q == 8'h00);
   wire last_bit    = (bit_q == 5'h00);
   wire [17:0] bit_mask = 18'h0_0001 << bit_q;
   wire [17:0] next_mask = 18'h0_0001 << (bit_q - 5'h01);
   wire [17:0] kept     = comp_s ? trial_q : (trial_q & ~bit_mask);

   always_comb begin
      state_d   = state_q;
      acq_cnt_d = acq_cnt_q;
      settle_d  = settle_q;
      bit_d     = bit_q;
      trial_d   = trial_q;
      result_d  = result_q;
      busy_d    = busy_q;
      case (state_q)
         sar_conv_pkg::ST_ACQ: begin
            if (!acq_done) begin
               acq_cnt_d = acq_cnt_q + 16'h0001;
            end else if (ctl_s.pd) begin
               state_d = sar_conv_pkg::ST_PDOWN;
            end else if (!ctl_s.conversion_start_n_n) begin
               state_d = sar_conv_pkg::ST_CONV;
            end else begin
               state_d = sar_conv_pkg::ST_WAIT;
            end
         end
         sar_conv_pkg::ST_WAIT: begin
            if (ctl_s.pd) begin
               state_d = sar_conv_pkg::ST_PDOWN;
            end else if (cnv_fall) begin
               state_d = sar_conv_pkg::ST_CONV;
            end
         end
         sar_conv_pkg::ST_CONV: begin
            if (!settle_done) begin
               settle_d = settle_q - 8'h01;
            end else if (last_bit) begin
               result_d  = kept;
               busy_d    = 1'b0;
               acq_cnt_d = 16'h0000;
               // Power-down only takes effect once this conversion is done.
               state_d   = ctl_s.pd ? sar_conv_pkg::ST_PDOWN : sar_conv_pkg::ST_ACQ;
            end else begin
               trial_d  = kept | next_mask;
               bit_d    = bit_q - 5'h01;
               settle_d = 8'(SETTLE_CYCLES - 1);
            end
         end
         sar_conv_pkg::ST_PDOWN: begin
            if (!ctl_s.pd) begin
               state_d   = sar_conv_pkg::ST_ACQ;
               acq_cnt_d = 16'h0000;
            end
         end
         default: begin
            state_d = sar_conv_pkg::ST_ACQ;
         end
      endcase
      // Entering conversion freezes the sample and loads the first trial.
      if (state_d == sar_conv_pkg::ST_CONV && state_q != sar_conv_pkg::ST_CONV) begin
         busy_d   = 1'b1;
         bit_d    = `SAR_MSB_IDX;
         trial_d  = `SAR_MSB_TRIAL;
         settle_d = 8'(SETTLE_CYCLES - 1);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q    <= sar_conv_pkg::ST_ACQ;
         acq_cnt_q  <= 16'h0000;
         settle_q   <= 8'h00;
         bit_q      <= 5'h00;
         trial_q    <= `SAR_ZERO18;
         result_q   <= `SAR_ZERO18;
         busy_q     <= 1'b0;
         cnv_prev_q <= 1'b1;
      end else begin
         state_q    <= state_d;
         acq_cnt_q  <= acq_cnt_d;
         settle_q   <= settle_d;
         bit_q      <= bit_d;
         trial_q    <= trial_d;
         result_q   <= result_d;
         busy_q     <= busy_d;
         cnv_prev_q <= ctl_s.conversion_start_n_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output bus.

   sar_conv_pkg::bus_sel_s bus_sel;
   logic [17:0] pin_val;
   logic [17:0] pin_oe;
   logic        ser_en;
   logic [17:0] data_q;
   logic [17:0] oe_q;
   logic        refbuf_en_q;

   // The select is used as it stands; the host keeps it still during a read.
   assign bus_sel = '{iface: ctl_s.iface, word_sel: cfg_s[`SAR_PIN_WORD],
                      byte_sel: cfg_s[`SAR_PIN_BYTE]};
   wire rd_active = !ctl_s.cs_n && !ctl_s.rd_n;
   wire full18    = (ctl_s.iface == `SAR_IF_PAR18);
   // The 18-bit format always reads straight binary, as pin 0 is a data pin there.
   wire twos_comp = !full18 && (cfg_s[`SAR_PIN_CODING] != `SAR_CODE_BINARY);
   wire [17:0] coded = {result_q[17] ^ twos_comp, result_q[16:0]};

   sar_bus_mux u_mux (
      .sel       (bus_sel),
      .code      (coded),
      .pin_val   (pin_val),
      .pin_oe    (pin_oe),
      .serial_en (ser_en)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         data_q      <= `SAR_ZERO18;
         oe_q        <= `SAR_ZERO18;
         refbuf_en_q <= 1'b0;
      end else begin
         data_q      <= pin_val;
         oe_q        <= rd_active ? pin_oe : `SAR_ZERO18;
         refbuf_en_q <= !ctl_s.refbuf_dis;
      end
   end

   assign data_out      = data_q;
   assign data_oe       = oe_q;
   assign busy          = busy_q;
   assign sample_hold   = (state_q == sar_conv_pkg::ST_CONV);
   assign dac_trial     = trial_q;
   assign refbuf_enable = refbuf_en_q;
   assign low_power     = (state_q == sar_conv_pkg::ST_PDOWN);
   assign serial_enable = ser_en;
   assign result_word   = coded;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   reset_idle_a: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> (!busy && state_q == sar_conv_pkg::ST_ACQ && data_oe == `SAR_ZERO18))
      else $error("reset did not return to idle acquisition");
   pd_no_start_a: assert property (
      (state_q == sar_conv_pkg::ST_PDOWN && ctl_s.pd) |=> !busy && !sample_hold)
      else $error("conversion started during power-down");
   wait_edge_a: assert property (
      (state_q == sar_conv_pkg::ST_WAIT && ctl_s.conversion_start_n_n) |=> state_q != sar_conv_pkg::ST_CONV)
      else $error("conversion started without a falling edge");
   start_now_a: assert property (
      (state_q == sar_conv_pkg::ST_ACQ && acq_done && !ctl_s.pd && !ctl_s.conversion_start_n_n)
      |=> state_q == sar_conv_pkg::ST_CONV && busy)
      else $error("low start level did not convert at once");
   refbuf_level_a: assert property (
      refbuf_enable == !$past(refbuf_disable, 3))
      else $error("reference buffer enable does not follow its pin");
   serial_off_a: assert property (
      (ctl_s.iface == `SAR_IF_SERIAL) |-> serial_enable ##1 data_oe == `SAR_ZERO18)
      else $error("parallel pins driven in serial format");
   full_word_a: assert property (
      (rd_active && full18 && $stable(result_q))
      |=> data_oe == `SAR_ONES18 && data_out == $past(result_q))
      else $error("18-bit format does not present the result");
   word_low_a: assert property (
      (rd_active && ctl_s.iface == `SAR_IF_WORD16 && cfg_s[1] && $stable(result_q))
      |=> data_out[17:4] == 14'h0000 && data_out[3:2] == $past(result_q[1:0]))
      else $error("low word layout wrong");
   word_high_a: assert property (
      (rd_active && ctl_s.iface == `SAR_IF_WORD16 && !cfg_s[`SAR_PIN_WORD])
      |=> data_oe == {16'hffff, 2'b00} && data_out[16:2] == $past(result_q[16:2]))
      else $error("high word layout wrong");
   byte_float_a: assert property (
      (rd_active && ctl_s.iface == `SAR_IF_BYTE8) |=> data_oe == {8'hff, 10'h000})
      else $error("byte format drives pins outside the top byte");
   byte_low_a: assert property (
      (rd_active && ctl_s.iface == `SAR_IF_BYTE8 && cfg_s[`SAR_PIN_WORD]
       && !cfg_s[`SAR_PIN_BYTE])
      |=> data_out[17:12] == 6'h00 && data_out[11:10] == $past(result_q[1:0]))
      else $error("low byte layout wrong");
   coding_sel_a: assert property (
      !full18 |-> result_word[16:0] == result_q[16:0]
      && ((result_word[17] != result_q[17]) == (cfg_s[`SAR_PIN_CODING] != `SAR_CODE_BINARY)))
      else $error("coding select not applied to the result");
   pd_entry_a: assert property (
      (state_q == sar_conv_pkg::ST_CONV && settle_done && last_bit && ctl_s.pd)
      |=> low_power && !busy)
      else $error("power-down not entered after the running conversion");
   bus_idle_a: assert property (
      !rd_active |=> data_oe == `SAR_ZERO18)
      else $error("data pins driven without chip select and read");
   busy_hold_a: assert property (
      $rose(busy) |-> busy [*8])
      else $error("busy fell before the conversion could finish");
   busy_latch_a: assert property (
      $fell(busy) |-> result_q == $past(kept) && !sample_hold)
      else $error("busy fell without latching the result");

   // Covers mark the scenarios the bench must reach: conversions, reads, power-down.
   conv_done_c: cover property ($fell(busy) ##[1:200] $rose(busy));
   byte_read_c: cover property (rd_active && ctl_s.iface == `SAR_IF_BYTE8
                                && cfg_s[`SAR_PIN_BYTE]);
   twos_read_c: cover property (rd_active && !full18 && !cfg_s[`SAR_PIN_CODING]);
   wait_start_c: cover property (state_q == sar_conv_pkg::ST_WAIT
                                 ##1 state_q == sar_conv_pkg::ST_CONV);
   pdown_c:     cover property (busy && ctl_s.pd ##[1:200] low_power);

endmodule

`default_nettype wire

// ---- core/sar_conv_map.svh ----
// Constants of the conversion control and output bus block.
// Assumes a single 250 MHz clock; included by bare name wherever needed.
`ifndef SAR_CONV_MAP_SVH
`define SAR_CONV_MAP_SVH

`define SAR_RES_BITS      18
`define SAR_MSB_IDX       5'h11
`define SAR_CLK_NS        4
// Acquisition and comparator settling times, in ns.
`define SAR_ACQ_NS        400
`define SAR_SETTLE_NS     20
`define SAR_ACQ_CYC       ((`SAR_ACQ_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_SETTLE_CYC    ((`SAR_SETTLE_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)

// Interface select encodings.
`define SAR_IF_PAR18      2'h0
`define SAR_IF_WORD16     2'h1
`define SAR_IF_BYTE8      2'h2
`define SAR_IF_SERIAL     2'h3

// Data pins shared with configuration inputs.
`define SAR_PIN_CODING    0
`define SAR_PIN_WORD      1
`define SAR_PIN_BYTE      2

// Level of the coding select that picks straight binary.
`define SAR_CODE_BINARY   1'b1
`define SAR_ZERO18        18'h0_0000
`define SAR_ONES18        18'h3_ffff
// First trial code of a conversion: only the MSB set.
`define SAR_MSB_TRIAL     18'h2_0000

`endif

// ---- core/sar_conv_pkg.sv ----
// Types shared by the conversion control and output bus modules.
// Assumes nothing of its surroundings.
package sar_conv_pkg;

   typedef enum logic [1:0] {
      ST_ACQ,
      ST_WAIT,
      ST_CONV,
      ST_PDOWN
   } conv_state_e;

   // Host control pins after synchronisation.
   typedef struct packed {
      logic       pd;
      logic       conversion_start_n_n;
      logic       refbuf_dis;
      logic [1:0] iface;
      logic       cs_n;
      logic       rd_n;
   } host_ctl_s;

   // Bus format selection as seen by the output multiplexer.
   typedef struct packed {
      logic [1:0] iface;
      logic       word_sel;
      logic       byte_sel;
   } bus_sel_s;

endpackage

// ---- core/sar_sync2.sv ----
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no word coherence is kept.
`timescale 1ns/1ps
`default_nettype none

module sar_sync2 #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

`default_nettype wire

// ---- core/sar_bus_mux.sv ----
// Output bus multiplexer: maps the coded result onto the 18 data pins.
// Assumes the caller registers the outputs and gates them with the read strobe.
`timescale 1ns/1ps
`include "sar_conv_map.svh"
`default_nettype none

module sar_bus_mux (
   input  wire sar_conv_pkg::bus_sel_s sel,
   input  wire logic [17:0]            code,
   output logic      [17:0]            pin_val,
   output logic      [17:0]            pin_oe,
   output logic                        serial_en
);

   wire is_p18  = (sel.iface == `SAR_IF_PAR18);
   wire is_w16  = (sel.iface == `SAR_IF_WORD16);
   wire is_b8   = (sel.iface == `SAR_IF_BYTE8);

   wire [17:0] word_hi  = {code[17:2], 2'b00};
   wire [17:0] word_lo  = {14'h0000, code[1:0], 2'b00};
   wire [7:0]  byte_v   = sel.word_sel ?
                          (sel.byte_sel ? {code[1:0], 6'h00} : {6'h00, code[1:0]}) :
                          (sel.byte_sel ? code[9:2] : code[17:10]);
   wire [17:0] byte_pin = {byte_v, 10'h000};
   wire [17:0] w16_pin  = sel.word_sel ? word_lo : word_hi;

   assign pin_val   = is_p18 ? code : (is_w16 ? w16_pin : (is_b8 ? byte_pin : `SAR_ZERO18));
   assign pin_oe    = is_p18 ? `SAR_ONES18 :
                      (is_w16 ? {16'hffff, 2'b00} : (is_b8 ? {8'hff, 10'h000} : `SAR_ZERO18));
   assign serial_en = (sel.iface == `SAR_IF_SERIAL);

endmodule

`default_nettype wire

// ---- verification/sar_front_model.sv ----
// Comparator front end model: holds the sampled level and compares it with the trial code.
// Assumes the trial code and the hold flag come straight from the converter's ports.
`timescale 1ns/1ps
`default_nettype none

module sar_front_model (
   input  wire logic        mclk,
   input  wire logic [17:0] level,
   input  wire logic        sample_hold,
   input  wire logic [17:0] dac_trial,
   output logic             comp_above
);
   logic [17:0] held_q;

   // The level is tracked until hold rises, so a late change of the level cannot leak in.
   always_ff @(posedge mclk) begin
      if (!sample_hold) begin
         held_q <= level;
      end
   end

   assign comp_above = ((sample_hold ? held_q : level) >= dac_trial);
endmodule
`default_nettype wire

// ---- verification/sar_conv_ctrl_tb_top.sv ----
// Self-checking bench of the conversion control and output bus block.
// Assumes the comparator front end model; host pins change on rising edges only.
`timescale 1ns/1ps
`default_nettype none

module sar_conv_ctrl_tb_top;
   localparam int ACQ      = 4;
   localparam int SET      = 3;
   localparam int BUSY_LEN = 18 * SET;

   logic        mclk    = 1'b0;
   logic        rst     = 1'b1;
   logic        pd      = 1'b0;
   logic        start_n = 1'b0;
   logic        rbd     = 1'b1;
   logic [1:0]  ifs     = 2'h0;
   logic        cs_n    = 1'b1;
   logic        rd_n    = 1'b1;
   logic [17:0] din     = 18'h0_0001;
   logic [17:0] level   = 18'h2_d5a3;
   logic        comp;
   logic [17:0] dout;
   logic [17:0] doe;
   logic [17:0] trial;
   logic [17:0] rword;
   logic        busy;
   logic        sh;
   logic        rbe;
   logic        lp;
   logic        sen;
   int          error_cnt = 0;
   int          cmp_count = 0;

   sar_conv_ctrl #(.ACQ_CYCLES(ACQ), .SETTLE_CYCLES(SET)) u_dut (
      .mclk(mclk), .rst(rst), .power_down_request(pd), .conversion_start_n(start_n),
      .refbuf_disable(rbd), .iface_sel0(ifs[0]), .iface_sel1(ifs[1]), .cs_n(cs_n),
      .rd_n(rd_n), .comp_above(comp), .data_in(din), .data_out(dout), .data_oe(doe),
      .busy(busy), .sample_hold(sh), .dac_trial(trial), .refbuf_enable(rbe),
      .low_power(lp), .serial_enable(sen), .result_word(rword));

   sar_front_model u_front (
      .mclk(mclk), .level(level), .sample_hold(sh), .dac_trial(trial), .comp_above(comp));

   always #2 mclk = ~mclk;

   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Outputs are sampled on falling edges, well clear of the launching rising edge.
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic wait_busy(input logic lvl, input int lim);
      int n;
      n = 0;
      while (busy !== lvl && n < lim) begin
         @(negedge mclk);
         n++;
      end
      check("busy wait", {17'h0, busy}, {17'h0, lvl});
   endtask

   task automatic run_conv(input logic [17:0] v, input int len);
      int n;
      n = 0;
      check("hold flag", {17'h0, sh}, 18'h0_0001);
      while (busy === 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      check("busy length", 18'(n), 18'(len));
      check("result word", rword, v);
   endtask

   task automatic rd(input logic [1:0] m, input logic ws, input logic bs, input logic cd,
                     input logic [17:0] r);
      logic [17:0] c;
      logic [17:0] oe;
      logic [17:0] v;
      c = (m != 2'h0 && !cd) ? r ^ 18'h2_0000 : r;
      oe = (m == 2'h0) ? 18'h3_ffff : (m == 2'h1) ? 18'h3_fffc
         : (m == 2'h2) ? 18'h3_fc00 : 18'h0_0000;
      v = (m == 2'h0) ? c
        : (m == 2'h1) ? (ws ? {14'h0, c[1:0], 2'h0} : {c[17:2], 2'h0})
        : (!ws) ? (bs ? {c[9:2], 10'h000} : {c[17:10], 10'h000})
        : (bs ? {c[1:0], 16'h0000} : {6'h00, c[1:0], 10'h000});
      @(posedge mclk) begin
         ifs <= m;
         din <= {15'h0, bs, ws, cd};
      end
      cyc(4);
      @(posedge mclk) begin
         cs_n <= 1'b0;
         rd_n <= 1'b0;
      end
      cyc(4);
      check("pin enable", doe, oe);
      check("pin value", dout & doe, v & oe);
      check("serial enable", {17'h0, sen}, {17'h0, m == 2'h3});
      @(posedge mclk) begin
         cs_n <= 1'b1;
         rd_n <= 1'b1;
      end
      cyc(4);
      check("pin release", doe, 18'h0_0000);
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      fork
         begin
            #40000;
            error_cnt++;
            print_verdict();
         end
      join_none
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      cyc(ACQ);
      check("busy after reset", {17'h0, busy}, 18'h0_0000);
      check("pins after reset", doe, 18'h0_0000);
      check("power after reset", {17'h0, lp}, 18'h0_0000);
      wait_busy(1'b1, 10);
      @(posedge mclk) start_n <= 1'b1;
      run_conv(18'h2_d5a3, BUSY_LEN);
      @(posedge mclk) rbd <= 1'b0;
      cyc(4);
      check("buffer on", {17'h0, rbe}, 18'h0_0001);
      @(posedge mclk) rbd <= 1'b1;
      cyc(4);
      check("buffer off", {17'h0, rbe}, 18'h0_0000);
      for (int k = 0; k < 16; k++) begin
         rd(k[3:2], k[1], k[0], k[1] ^ k[0], 18'h2_d5a3);
      end
      @(posedge mclk) begin
         din <= 18'h0_0001;
         level <= 18'h1_0ff0;
      end
      cyc(ACQ + 8);
      check("no start without edge", {17'h0, busy}, 18'h0_0000);
      @(posedge mclk) start_n <= 1'b0;
      wait_busy(1'b1, 6);
      run_conv(18'h1_0ff0, BUSY_LEN);
      @(posedge mclk) level <= 18'h3_ffff;
      wait_busy(1'b1, ACQ + 12);
      // Power-down is raised mid-conversion, which must still run to its end.
      @(posedge mclk) pd <= 1'b1;
      run_conv(18'h3_ffff, BUSY_LEN);
      cyc(3);
      check("low power", {17'h0, lp}, 18'h0_0001);
      cyc(20);
      check("start refused", {17'h0, busy}, 18'h0_0000);
      @(posedge mclk) begin
         pd <= 1'b0;
         level <= 18'h0_0000;
      end
      wait_busy(1'b1, ACQ + 12);
      @(posedge mclk) start_n <= 1'b1;
      run_conv(18'h0_0000, BUSY_LEN);
      @(posedge mclk) level <= 18'h0_5555;
      cyc(ACQ + 4);
      @(posedge mclk) start_n <= 1'b0;
      wait_busy(1'b1, 6);
      @(posedge mclk) start_n <= 1'b1;
      cyc(10);
      // A reset in mid-conversion must leave the previous result cleared, not the new one.
      @(posedge mclk) rst <= 1'b1;
      cyc(2);
      check("busy in reset", {17'h0, busy}, 18'h0_0000);
      check("hold in reset", {17'h0, sh}, 18'h0_0000);
      @(posedge mclk) rst <= 1'b0;
      cyc(4);
      check("result cleared", rword, 18'h0_0000);
      print_verdict();
   end
endmodule
`default_nettype wire
